// [rtl/mcs_pkg.sv]
package mcs_pkg;
  // Register map: word offsets on the register access port.
  localparam logic [7:0] CONTROL_FUNCTION_TWO_ADDR = 8'h01;
  localparam logic [7:0] USER_SYNC_CONFIG_ADDR = 8'h1b;
  localparam logic [31:0] CONTROL_FUNCTION_TWO_RESET = 32'h0000_0900;
  localparam logic [31:0] USER_SYNC_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_FUNCTION_TWO_MASK = 32'h0000_ff00;
  localparam logic [31:0] USER_SYNC_CONFIG_MASK = 32'h0000_007f;
  // Field positions.
  localparam int GEN_ENABLE_BIT = 9;
  localparam int MUX_ENABLE_BIT = 8;
  localparam int SYNC_ENABLE_BIT = 6;
  localparam int OUT_DELAY_LSB = 3;
  localparam int IN_DELAY_LSB = 0;
  localparam int DELAY_WIDTH = 3;
  localparam int STATE_LSB = 24;
  localparam int CAL_DONE_BIT = 28;
  // Typical delay figures in picoseconds.
  localparam int OUT_DELAY_FIRST_STEP_PS = 170;
  localparam int OUT_DELAY_STEP_PS = 300;
  localparam int OUT_DELAY_TOTAL_PS = 1970;
  localparam int IN_DELAY_TOTAL_PS = 1200;
  // Sync generator divider.
  localparam int SYNC_DIVIDE = 384;
  localparam int SYNC_HIGH_CYCLES = 256;
  localparam int DIV_WIDTH = 9;
  // Internal clock generator counter.
  localparam int CLKGEN_WIDTH = 4;
  localparam logic [3:0] CLKGEN_PRESET = 4'h0;
  // Calibration timing.
  localparam int CAL_SYNC_CYCLES = 16;
  localparam int CAL_STEP_NS = 400;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CAL_STEP_CYCLES = (CAL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {CAL_IDLE, CAL_FIRST, CAL_WAIT, CAL_FINISH, CAL_DONE} mcs_cal_type;
endpackage : mcs_pkg

// [rtl/mcs_edge.sv]
// Two-stage synchroniser followed by a rising edge detector.
module mcs_edge
  import mcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous level in, synchronised level and edge pulse out.
  input wire logic async_in,
  output logic level,
  output logic rise
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // Next values of the synchroniser and edge history.
  always_comb
  begin
    next_meta = async_in;
    next_sync = meta;
    next_prev = sync;
  end

  // Register stage.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // One cycle pulse per rising edge, from the second stage only onward.
  assign rise = sync & ~prev;
  assign level = sync;
endmodule : mcs_edge

// [rtl/mcs_sync.sv]
// Contract
// - Bits 5 to 3 of the user sync configuration register hold the outgoing timing delay code.
// - Bits 2 to 0 of the user sync configuration register hold the incoming timing delay code.
// - Output delay codes step by 0.17 ns first and 0.3 ns afterwards, about 1.97 ns in total.
// - Input delay codes 0 to 7 span about 1.2 ns in total.
// - A device that is not the master passes its timing input through to the timing output.
// - Each rising edge of the timing input, sampled on the core clock, gives a one-cycle pulse.
// - The clock generator counter is loaded with a fixed state whenever the pulse is high.
// - The preset state lasts one core clock cycle, then the counter steps on as usual.
// - The generator drives the output only with both enables set; generator off passes the input.
// - The sync generator divides the core clock by 384 with a two-thirds duty cycle.
// - With sync enabled, calibration waits after its first step for 16 timing input cycles.
module mcs_sync
  import mcs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register access port.
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  output logic [31:0] reg_rd_data,
  // Timing pins.
  input wire logic sync_in,
  output logic sync_out,
  // Delay element settings.
  output logic [2:0] out_delay_code,
  output logic [2:0] in_delay_code,
  // Internal clock generator state.
  output logic [3:0] clock_state,
  // Calibration control.
  input wire logic cal_request,
  output logic cal_busy,
  output logic cal_done
);
  logic [31:0] control_function_two;
  logic [31:0] user_sync_config;
  logic [31:0] next_control_function_two;
  logic [31:0] next_user_sync_config;
  logic [31:0] next_reg_rd_data;
  logic in_level;
  logic sync_pulse;
  logic [CLKGEN_WIDTH-1:0] next_clock_state;
  logic [DIV_WIDTH-1:0] div_count;
  logic [DIV_WIDTH-1:0] next_div_count;
  logic gen_level;
  logic next_gen_level;
  logic next_sync_out;
  mcs_cal_type cal_state;
  mcs_cal_type next_cal_state;
  logic [4:0] cal_count;
  logic [4:0] next_cal_count;
  logic gen_en;
  logic mux_en;

  // Synchronise the timing input and detect its rising edges.
  mcs_edge u_edge
  (
    .clk(clk),
    .resetn(resetn),
    .async_in(sync_in),
    .level(in_level),
    .rise(sync_pulse)
  );

  assign gen_en = control_function_two[GEN_ENABLE_BIT];
  assign mux_en = control_function_two[MUX_ENABLE_BIT];

  // Register writes and registered read data.
  always_comb
  begin
    next_control_function_two = control_function_two;
    next_user_sync_config = user_sync_config;
    next_reg_rd_data = reg_rd_data;
    if (reg_wr_en && reg_addr == CONTROL_FUNCTION_TWO_ADDR)
    begin
      next_control_function_two = reg_wr_data & CONTROL_FUNCTION_TWO_MASK;
    end
    if (reg_wr_en && reg_addr == USER_SYNC_CONFIG_ADDR)
    begin
      next_user_sync_config = reg_wr_data & USER_SYNC_CONFIG_MASK;
    end
    if (reg_rd_en)
    begin
      case (reg_addr)
        CONTROL_FUNCTION_TWO_ADDR: next_reg_rd_data = control_function_two;
        USER_SYNC_CONFIG_ADDR:
        begin
          next_reg_rd_data = user_sync_config;
          next_reg_rd_data[STATE_LSB +: CLKGEN_WIDTH] = clock_state;
          next_reg_rd_data[CAL_DONE_BIT] = cal_done;
        end
        default: next_reg_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      control_function_two <= CONTROL_FUNCTION_TWO_RESET;
      user_sync_config <= USER_SYNC_CONFIG_RESET;
      reg_rd_data <= 32'h0000_0000;
    end
    else
    begin
      control_function_two <= next_control_function_two;
      user_sync_config <= next_user_sync_config;
      reg_rd_data <= next_reg_rd_data;
    end
  end

  // Delay codes go straight from the register to the delay elements.
  assign out_delay_code = user_sync_config[OUT_DELAY_LSB +: DELAY_WIDTH];
  assign in_delay_code = user_sync_config[IN_DELAY_LSB +: DELAY_WIDTH];

  // Clock generator: preset on the sync pulse, otherwise step once per cycle.
  always_comb
  begin
    if (sync_pulse)
    begin
      next_clock_state = CLKGEN_PRESET;
    end
    else
    begin
      next_clock_state = clock_state + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      clock_state <= CLKGEN_PRESET;
    end
    else
    begin
      clock_state <= next_clock_state;
    end
  end

  // Free running divider and output selection.
  always_comb
  begin
    if (div_count == DIV_WIDTH'(SYNC_DIVIDE - 1))
    begin
      next_div_count = '0;
    end
    else
    begin
      next_div_count = div_count + 9'h001;
    end
    next_gen_level = (next_div_count < DIV_WIDTH'(SYNC_HIGH_CYCLES));
    if (!gen_en)
    begin
      next_sync_out = in_level;
    end
    else if (mux_en)
    begin
      next_sync_out = next_gen_level;
    end
    else
    begin
      next_sync_out = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      div_count <= '0;
      gen_level <= 1'b1;
      sync_out <= 1'b0;
    end
    else
    begin
      div_count <= next_div_count;
      gen_level <= next_gen_level;
      sync_out <= next_sync_out;
    end
  end

  // Calibration sequence with an optional pause for sync pulses.
  always_comb
  begin
    next_cal_state = cal_state;
    next_cal_count = cal_count;
    case (cal_state)
      CAL_IDLE, CAL_DONE:
      begin
        if (cal_request)
        begin
          next_cal_state = CAL_FIRST;
          next_cal_count = '0;
        end
      end
      CAL_FIRST:
      begin
        if (cal_count == 5'(CAL_STEP_CYCLES - 1))
        begin
          next_cal_count = '0;
          next_cal_state = user_sync_config[SYNC_ENABLE_BIT] ? CAL_WAIT : CAL_FINISH;
        end
        else
        begin
          next_cal_count = cal_count + 5'h01;
        end
      end
      CAL_WAIT:
      begin
        if (sync_pulse)
        begin
          if (cal_count == 5'(CAL_SYNC_CYCLES - 1))
          begin
            next_cal_count = '0;
            next_cal_state = CAL_FINISH;
          end
          else
          begin
            next_cal_count = cal_count + 5'h01;
          end
        end
      end
      CAL_FINISH:
      begin
        if (cal_count == 5'(CAL_STEP_CYCLES - 1))
        begin
          next_cal_count = '0;
          next_cal_state = CAL_DONE;
        end
        else
        begin
          next_cal_count = cal_count + 5'h01;
        end
      end
      default:
      begin
        next_cal_state = CAL_IDLE;
        next_cal_count = '0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cal_state <= CAL_IDLE;
      cal_count <= '0;
    end
    else
    begin
      cal_state <= next_cal_state;
      cal_count <= next_cal_count;
    end
  end

  assign cal_busy = (cal_state == CAL_FIRST) || (cal_state == CAL_WAIT) || (cal_state == CAL_FINISH);
  assign cal_done = (cal_state == CAL_DONE);

  // Checks next to the logic they guard.
  sequence s_preset;
    sync_pulse ##1 (clock_state == CLKGEN_PRESET);
  endsequence

  a_pulse_single: assert property (@(posedge clk) disable iff (!resetn)
    sync_pulse |=> !sync_pulse) else $error("sync pulse longer than one cycle");
  a_pulse_cause: assert property (@(posedge clk) disable iff (!resetn)
    sync_pulse |-> in_level && !$past(in_level)) else $error("sync pulse without rising edge");
  a_preset_load: assert property (@(posedge clk) disable iff (!resetn)
    sync_pulse |=> clock_state == CLKGEN_PRESET) else $error("clock generator not preset");
  a_preset_hold: assert property (@(posedge clk) disable iff (!resetn)
    s_preset ##0 !sync_pulse |=> clock_state == CLKGEN_PRESET + 4'h1) else $error("preset held too long");
  a_delay_static: assert property (@(posedge clk) disable iff (!resetn)
    !$past(reg_wr_en) |-> $stable(out_delay_code) && $stable(in_delay_code)) else $error("delay code moved");
  a_gen_duty: assert property (@(posedge clk) disable iff (!resetn)
    div_count == 9'h0ff ##1 div_count == 9'h100 |-> !gen_level) else $error("generator high time wrong");
  a_gen_wrap: assert property (@(posedge clk) disable iff (!resetn)
    div_count == 9'h17f |=> div_count == 9'h000 && gen_level) else $error("generator period wrong");
  a_out_select: assert property (@(posedge clk) disable iff (!resetn)
    gen_en && !mux_en |=> !sync_out) else $error("generator output not gated");
  a_pass_through: assert property (@(posedge clk) disable iff (!resetn)
    !gen_en |=> sync_out == $past(in_level)) else $error("timing input not passed through");
  a_cal_pause: assert property (@(posedge clk) disable iff (!resetn)
    cal_state == CAL_WAIT && !sync_pulse |=> cal_state == CAL_WAIT) else $error("calibration left pause early");
endmodule : mcs_sync

// [test/mcs_sync_source.sv]
// Far-side timing source: the redistributed sync line from a master.
module mcs_sync_source
(
  // Clock and enable.
  input wire logic clk,
  input wire logic en,
  // Timing line to the device.
  output logic sync_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial sync_in = 1'b0;
  // Twelve-cycle period, edges kept away from the sampling edge.
  always @(negedge clk)
  begin
    cnt <= (cnt == 11) ? 0 : cnt + 1;
    sync_in <= en && (cnt < 6);
  end
endmodule : mcs_sync_source

// [test/tb_multichip_clock_state_sync.sv]
module tb_multichip_clock_state_sync
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, cal_req = 1'b0, src_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [31:0] seed = 32'h0001_4f15;
  logic sync_in, sync_out, cal_busy, cal_done;
  logic [2:0] od, id;
  logic [2:0] hist = 3'h0;
  logic [3:0] st;
  int fails = 0, n_compared = 0, k, n, pulses = 0;
  mcs_sync u_dut (.clk(clk), .resetn(resetn), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_rd_data(rdata), .sync_in(sync_in), .sync_out(sync_out),
    .out_delay_code(od), .in_delay_code(id), .clock_state(st), .cal_request(cal_req),
    .cal_busy(cal_busy), .cal_done(cal_done));
  mcs_sync_source u_src (.clk(clk), .en(src_en), .sync_in(sync_in));
  // Clock at 100 ns.
  initial forever #50 clk = ~clk;
  // Pin history, so the passed-through output can be compared.
  always @(posedge clk) hist <= {hist[1:0], sync_in};
  // Timing edges seen while calibration runs.
  always @(posedge sync_in) if (cal_busy === 1'b1) pulses++;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Value a register should hold after a write.
  function automatic logic [31:0] stored(input logic [7:0] a, input logic [31:0] v);
    return (a == USER_SYNC_CONFIG_ADDR) ? (v & 32'h0000_007f) :
      (a == CONTROL_FUNCTION_TWO_ADDR) ? (v & 32'h0000_ff00) : 32'h0;
  endfunction : stored
  // One register access; read data lands in d.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    {wr, rd, addr, wdata} = {w, !w, a, v};
    @(negedge clk);
    {wr, rd} = 2'b00;
    @(negedge clk);
    d = rdata;
  endtask : acc
  // Counts cycles until the chosen output reaches a level.
  task automatic cnt_until(input logic [1:0] sel, input logic v);
    logic s;
    n = 0;
    s = !v;
    while (s !== v && n < 500)
    begin
      @(negedge clk);
      #1;
      s = (sel == 2'h0) ? sync_in : (sel == 2'h1) ? sync_out : cal_done;
      n++;
    end
    if (s !== v) fails++;
  endtask : cnt_until
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Watchdog far beyond the expected run length.
  initial
  begin
    #(100 * 30000);
    fails++;
    report_and_stop;
  end
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    acc(0, CONTROL_FUNCTION_TWO_ADDR, 32'h0);
    `CHK("control reset", CONTROL_FUNCTION_TWO_RESET, d)
    acc(0, USER_SYNC_CONFIG_ADDR, 32'h0);
    `CHK("usr reset", USER_SYNC_CONFIG_RESET, d & 32'h10ff_ffff)
    $display("test reset done");
    for (k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      acc(1, USER_SYNC_CONFIG_ADDR, seed);
      `CHK("out delay", seed[5:3], od)
      `CHK("in delay", seed[2:0], id)
      acc(1, seed[15:8] | 8'h20, ~seed);
      acc(0, seed[15:8] | 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, d)
      `CHK("held delay", seed[5:0], {od, id})
      acc(0, USER_SYNC_CONFIG_ADDR, 32'h0);
      `CHK("usr read", stored(USER_SYNC_CONFIG_ADDR, seed), d & 32'h00ff_ffff)
      acc(1, CONTROL_FUNCTION_TWO_ADDR, seed);
      acc(0, CONTROL_FUNCTION_TWO_ADDR, 32'h0);
      `CHK("control read", stored(CONTROL_FUNCTION_TWO_ADDR, seed), d)
    end
    $display("test registers done");
    src_en = 1'b1;
    // The second pass lands where a free running counter would not be at the preset state.
    for (k = 0; k < 2; k++)
    begin
      cnt_until(2'h0, 1'b0);
      cnt_until(2'h0, 1'b1);
      repeat (3) @(negedge clk);
      `CHK("preset", CLKGEN_PRESET, st)
      @(negedge clk);
      `CHK("step", CLKGEN_PRESET + 4'h1, st)
    end
    $display("test preset done");
    acc(1, CONTROL_FUNCTION_TWO_ADDR, 32'h0000_0100);
    for (k = 0; k < 40; k++)
    begin
      @(negedge clk);
      `CHK("pass through", hist[2], sync_out)
    end
    acc(1, CONTROL_FUNCTION_TWO_ADDR, 32'h0000_0200);
    for (k = 0; k < 40; k++)
    begin
      @(negedge clk);
      `CHK("mux off", 1'b0, sync_out)
    end
    acc(1, CONTROL_FUNCTION_TWO_ADDR, 32'h0000_0300);
    cnt_until(2'h1, 1'b0);
    cnt_until(2'h1, 1'b1);
    cnt_until(2'h1, 1'b0);
    `CHK("gen high", SYNC_HIGH_CYCLES, n)
    cnt_until(2'h1, 1'b1);
    `CHK("gen low", SYNC_DIVIDE - SYNC_HIGH_CYCLES, n)
    $display("test sync out done");
    src_en = 1'b0;
    acc(1, USER_SYNC_CONFIG_ADDR, 32'h0000_0040);
    @(negedge clk);
    cal_req = 1'b1;
    @(negedge clk);
    cal_req = 1'b0;
    `CHK("cal busy", 1'b1, cal_busy)
    repeat (200) @(negedge clk);
    `CHK("cal stalls", 1'b0, cal_done)
    `CHK("cal waits", 1'b1, cal_busy)
    pulses = 0;
    src_en = 1'b1;
    cnt_until(2'h2, 1'b1);
    `CHK("sync pulses", 16, pulses)
    acc(0, USER_SYNC_CONFIG_ADDR, 32'h0);
    `CHK("done bit", 1'b1, d[CAL_DONE_BIT])
    acc(1, USER_SYNC_CONFIG_ADDR, 32'h0);
    @(negedge clk);
    cal_req = 1'b1;
    @(negedge clk);
    cal_req = 1'b0;
    cnt_until(2'h2, 1'b1);
    `CHK("plain cal", 2 * CAL_STEP_CYCLES, n)
    $display("test calibration done");
    report_and_stop;
  end
endmodule : tb_multichip_clock_state_sync
